// *** shared/epi_pkg.sv ***
`default_nettype none
package epi_pkg;

   // Register bus geometry
   localparam int unsigned EPI_ADDR_W  = 8;
   localparam int unsigned EPI_DATA_W  = 32;
   localparam int unsigned EPI_NUM_IN  = 3;

   // Register offsets (byte addresses)
   localparam logic [7:0] EPI_OFS_CTRL   = 8'h00;
   localparam logic [7:0] EPI_OFS_ENABLE = 8'h04;
   localparam logic [7:0] EPI_OFS_STATUS = 8'h08;
   localparam logic [7:0] EPI_OFS_CLEAR  = 8'h0C;

   // Control register fields
   localparam int unsigned EPI_CTRL_SEL_LSB = 0;   // Two bits per input, inputs zero and one
   localparam int unsigned EPI_CTRL_SEL_W   = 2;
   localparam int unsigned EPI_CTRL_POL_BIT = 4;   // Edge polarity of input two
   localparam int unsigned EPI_CTRL_W       = 5;

   // Status register fields
   localparam int unsigned EPI_STAT_PEND_LSB = 0;
   localparam int unsigned EPI_STAT_LVL_LSB  = 8;

   // Reset values
   localparam logic [4:0] EPI_CTRL_RST   = 5'h00;
   localparam logic [2:0] EPI_ENABLE_RST = 3'h0;

   // Start-up fuse width
   localparam int unsigned EPI_SUT_W = 4;

   // Sense selector encoding
   localparam logic [1:0] EPI_SENSE_LOW  = 2'h0;
   localparam logic [1:0] EPI_SENSE_ANY  = 2'h1;
   localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
   localparam logic [1:0] EPI_SENSE_RISE = 2'h3;

   // Wake sampler states
   typedef enum logic [1:0] {
      EPI_WK_IDLE,
      EPI_WK_SAMPLE,
      EPI_WK_START
   } epi_wake_t;

   // Register bus request
   typedef struct packed {
      logic [EPI_ADDR_W-1:0] addr;
      logic [EPI_DATA_W-1:0] wdata;
      logic                  wr;
      logic                  rd;
   } epi_bus_req_t;

endpackage
`default_nettype wire

// *** logic/epi_wake_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none
module epi_wake_sampler #(
   parameter int unsigned SUT_W = epi_pkg::EPI_SUT_W
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic             arm,
   input  wire logic             level_low,
   input  wire logic             kick,
   input  wire logic             wdt_tick,
   input  wire logic [SUT_W-1:0] startup_ticks,
   output logic                  busy,
   output logic                  done
);

   typedef struct packed {
      epi_pkg::epi_wake_t state;
      logic [SUT_W-1:0]   cnt;
      logic               busy;
      logic               done;
   } epi_wk_st_t;

   epi_wk_st_t st_reg;
   epi_wk_st_t st_next;

   // Two watchdog samples, then start-up count
   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      case (st_reg.state)
         epi_pkg::EPI_WK_IDLE: begin
            st_next.cnt = '0;
            if (kick) begin
               st_next.state = epi_pkg::EPI_WK_START;
            end else if (arm && level_low && wdt_tick) begin
               st_next.state = epi_pkg::EPI_WK_SAMPLE;
            end
         end
         epi_pkg::EPI_WK_SAMPLE: begin
            if (!arm) begin
               st_next.state = epi_pkg::EPI_WK_IDLE;
            end else if (wdt_tick) begin
               st_next.state = level_low ? epi_pkg::EPI_WK_START : epi_pkg::EPI_WK_IDLE;
            end
         end
         epi_pkg::EPI_WK_START: begin
            if (st_reg.cnt >= startup_ticks) begin
               st_next.done  = 1'b1;
               st_next.state = epi_pkg::EPI_WK_IDLE;
            end else if (wdt_tick) begin
               st_next.cnt = SUT_W'(st_reg.cnt + 1'b1);
            end
         end
         default: begin
            st_next.state = epi_pkg::EPI_WK_IDLE;
         end
      endcase
      st_next.busy = (st_next.state == epi_pkg::EPI_WK_START);
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_reg <= '{state: epi_pkg::EPI_WK_IDLE, cnt: '0, busy: 1'b0, done: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign busy = st_reg.busy;
   assign done = st_reg.done;

   chk_sample_abort: assert property (@(posedge clk) disable iff (!rstn)
      st_reg.state == epi_pkg::EPI_WK_SAMPLE && arm && wdt_tick && !level_low
      |=> st_reg.state == epi_pkg::EPI_WK_IDLE)
      else $error("wake sampler kept going after a failed sample");

endmodule // epi_wake_sampler
`default_nettype wire

// *** logic/epi_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module epi_top #(
   parameter int unsigned SUT_W = epi_pkg::EPI_SUT_W
) (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire logic                     ext_irq_pin_zero,
   input  wire logic                     ext_irq_pin_one,
   input  wire logic                     ext_irq_pin_two,
   input  wire logic [2:0]               pin_drive_en,
   input  wire logic [2:0]               pin_drive_val,
   input  wire logic                     sleep_active,
   input  wire logic                     sleep_is_idle,
   input  wire logic                     wdt_tick,
   input  wire logic [SUT_W-1:0]         startup_time_fuses,
   input  wire logic [2:0]               irq_ack,
   input  wire epi_pkg::epi_bus_req_t    bus_req,
   output logic [epi_pkg::EPI_DATA_W-1:0] bus_rdata,
   output logic [2:0]                    irq_req,
   output logic                          irq_out,
   output logic                          wake_req,
   output logic                          osc_start
);

   localparam int unsigned N = epi_pkg::EPI_NUM_IN;

   // Refuse fuse widths the counter cannot serve
   if (SUT_W < 1 || SUT_W > 16) begin : g_bad_sut
      $error("SUT_W must lie between 1 and 16");
   end

   typedef struct packed {
      logic [N-1:0]                    sync1;
      logic [N-1:0]                    sync2;
      logic [N-1:0]                    prev;
      logic [epi_pkg::EPI_CTRL_W-1:0]  ctrl;
      logic [N-1:0]                    enable;
      logic [N-1:0]                    pending;
      logic [N-1:0]                    irq_req;
      logic                            irq;
      logic                            wake;
      logic                            osc_start;
      logic [epi_pkg::EPI_DATA_W-1:0]  rdata;
   } epi_state_t;

   epi_state_t st_reg;
   epi_state_t st_next;

   logic [N-1:0] pin_raw;
   logic [N-1:0] lvl;
   logic [N-1:0] rise;
   logic [N-1:0] fall;
   logic [N-1:0] evt;
   logic [N-1:0] lvl_mode;
   logic [N-1:0] lvl_req;
   logic         io_clk_run;
   logic         pwr_down;
   logic         wk_busy;
   logic         wk_done;
   logic         wk_kick;
   logic         pol_two;

   assign pin_raw = {ext_irq_pin_two, ext_irq_pin_one, ext_irq_pin_zero};

   assign io_clk_run = !sleep_active || sleep_is_idle;
   assign pwr_down   = sleep_active && !sleep_is_idle;

   // own drive seen as pin level
   assign lvl  = (pin_drive_en & pin_drive_val) | (~pin_drive_en & st_reg.sync2);
   assign rise = lvl & ~st_reg.prev;
   assign fall = ~lvl & st_reg.prev;

   // Per-input sensing for inputs zero and one
   for (genvar ch = 0; ch < 2; ch++) begin : g_sense
      logic [epi_pkg::EPI_CTRL_SEL_W-1:0] sel;
      logic                               hit;
      assign sel = st_reg.ctrl[epi_pkg::EPI_CTRL_SEL_LSB + ch*epi_pkg::EPI_CTRL_SEL_W
                               +: epi_pkg::EPI_CTRL_SEL_W];
      always_comb begin
         case (sel)
            epi_pkg::EPI_SENSE_ANY:  hit = rise[ch] | fall[ch];
            epi_pkg::EPI_SENSE_FALL: hit = fall[ch];
            epi_pkg::EPI_SENSE_RISE: hit = rise[ch];
            default:                 hit = 1'b0;
         endcase
      end
      // clocked edges only with I/O clock
      assign evt[ch]      = hit && io_clk_run;
      assign lvl_mode[ch] = (sel == epi_pkg::EPI_SENSE_LOW);
      assign lvl_req[ch]  = lvl_mode[ch] && st_reg.enable[ch] && !lvl[ch];
   end

   assign pol_two     = st_reg.ctrl[epi_pkg::EPI_CTRL_POL_BIT];
   // input two edge only, no I/O clock needed
   assign evt[2]      = pol_two ? rise[2] : fall[2];
   assign lvl_mode[2] = 1'b0;
   assign lvl_req[2]  = 1'b0;

   // pin two edge starts wake-up in deep sleep
   assign wk_kick = pwr_down && evt[2] && st_reg.enable[2];

   // Power-down wake sampling on watchdog ticks
   epi_wake_sampler #(
      .SUT_W (SUT_W)
   ) u_wake (
      .clk           (clk),
      .rstn          (rstn),
      .arm           (pwr_down),
      .level_low     (|lvl_req),
      .kick          (wk_kick),
      .wdt_tick      (wdt_tick),
      .startup_ticks (startup_time_fuses),
      .busy          (wk_busy),
      .done          (wk_done)
   );

   // Next-state logic
   always_comb begin
      logic [N-1:0] clr;
      logic         wr_hit;
      st_next       = st_reg;
      clr           = irq_ack;
      wr_hit        = 1'b0;

      st_next.sync1 = pin_raw;
      st_next.sync2 = st_reg.sync1;
      st_next.prev  = lvl;

      // Register writes
      if (bus_req.wr) begin
         case (bus_req.addr)
            epi_pkg::EPI_OFS_CTRL: begin
               st_next.ctrl = bus_req.wdata[epi_pkg::EPI_CTRL_W-1:0];
            end
            epi_pkg::EPI_OFS_ENABLE: begin
               st_next.enable = bus_req.wdata[N-1:0];
            end
            epi_pkg::EPI_OFS_CLEAR: begin
               wr_hit = 1'b1;
            end
            default: begin
               wr_hit = 1'b0;
            end
         endcase
      end
      if (wr_hit) begin
         clr = clr | bus_req.wdata[N-1:0];
      end

      // set wins over clear, level mode keeps clear
      st_next.pending = ((st_reg.pending & ~clr) | evt) & ~lvl_mode;

      // per-input request, level gated in power-down
      st_next.irq_req = (st_next.pending & st_next.enable) | (lvl_req & {N{!pwr_down}});
      st_next.irq     = |st_next.irq_req;

      // deep wake via sampler, idle wake on any request
      if (!sleep_active) begin
         st_next.wake = 1'b0;
      end else if ((sleep_is_idle && st_next.irq) || (!sleep_is_idle && wk_done)) begin
         st_next.wake = 1'b1;
      end
      st_next.osc_start = wk_busy;

      // Read data, valid one cycle after the strobe
      st_next.rdata = '0;
      if (bus_req.rd) begin
         case (bus_req.addr)
            epi_pkg::EPI_OFS_CTRL: begin
               st_next.rdata[epi_pkg::EPI_CTRL_W-1:0] = st_reg.ctrl;
            end
            epi_pkg::EPI_OFS_ENABLE: begin
               st_next.rdata[N-1:0] = st_reg.enable;
            end
            epi_pkg::EPI_OFS_STATUS: begin
               st_next.rdata[epi_pkg::EPI_STAT_PEND_LSB +: N] = st_reg.pending;
               st_next.rdata[epi_pkg::EPI_STAT_LVL_LSB +: N]  = lvl;
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_reg           <= '0;
         st_reg.ctrl      <= epi_pkg::EPI_CTRL_RST;
         st_reg.enable    <= epi_pkg::EPI_ENABLE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign bus_rdata = st_reg.rdata;
   assign irq_req   = st_reg.irq_req;
   assign irq_out   = st_reg.irq;
   assign wake_req  = st_reg.wake;
   assign osc_start = st_reg.osc_start;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   chk_level_flag_clear: assert property (
      g_sense[0].sel == epi_pkg::EPI_SENSE_LOW |=> !st_reg.pending[0])
      else $error("pending flag set while input zero in level mode");

   chk_rise_sets_flag: assert property (
      io_clk_run && g_sense[0].sel == epi_pkg::EPI_SENSE_RISE && rise[0]
      |=> st_reg.pending[0])
      else $error("rising edge on input zero missed");

   chk_fall_two_flag: assert property (
      !pol_two && fall[2] |=> st_reg.pending[2])
      else $error("falling edge on input two missed");

   // no clocked edges without I/O clock
   chk_io_clk_gate: assert property (
      !io_clk_run && !st_reg.pending[0] |=> !st_reg.pending[0])
      else $error("input zero flag set with I/O clock halted");

   chk_level_holds: assert property (
      g_sense[1].sel == epi_pkg::EPI_SENSE_LOW && st_reg.enable[1] && !lvl[1] && !pwr_down
      |=> irq_req[1] && irq_out)
      else $error("low level on input one not requesting");

   // event wins over a same-cycle clear
   chk_set_wins: assert property (
      evt[2] && bus_req.wr && bus_req.addr == epi_pkg::EPI_OFS_CLEAR
      |=> st_reg.pending[2])
      else $error("clear beat a same-cycle event");

   // clocked edges never wake deep sleep
   chk_deep_wake_src: assert property (
      $rose(wake_req) |-> $past(sleep_is_idle) || $past(wk_done))
      else $error("deep sleep woken without sampler completion");

   // pin reaches the level two edges later
   chk_sync_delay: assert property (
      $past(rstn, 2) && !pin_drive_en[2] ##0 $stable(pin_raw[2]) [*3]
      |-> lvl[2] == pin_raw[2])
      else $error("synchroniser delay wrong on input two");

   // input two senses edges in deep sleep
   chk_two_async: assert property (
      pwr_down && evt[2] |=> st_reg.pending[2])
      else $error("input two edge missed in deep sleep");

   cov_rise_zero: cover property (
      g_sense[0].sel == epi_pkg::EPI_SENSE_RISE && rise[0] ##1 irq_req[0]);
   cov_deep_wake: cover property (wk_busy ##[1:200] $rose(wake_req));
   cov_level_req: cover property (lvl_req[1] ##1 irq_req[1] [*4]);
   cov_any_change: cover property (
      g_sense[1].sel == epi_pkg::EPI_SENSE_ANY && fall[1] ##1 st_reg.pending[1]);

endmodule // epi_top
`default_nettype wire

// *** tb/epi_pin_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pad drivers for the three interrupt pins
module epi_pin_src (
   input  wire logic       clk,
   input  wire logic [2:0] target,
   input  wire logic [2:0] hold,
   input  wire logic       wake_req,
   output logic      [2:0] pins = 3'h7
);
   logic woke_reg = 1'h0;
   logic done_reg = 1'h0;
   // Pads move just after the clock edge
   always @(posedge clk) begin
      woke_reg <= wake_req;
      done_reg <= (done_reg | (woke_reg & ~wake_req)) & (hold != 3'h0);
      pins <= target & ~(hold & {3{~done_reg}});
   end
endmodule // epi_pin_src
`default_nettype wire

// *** tb/external_pin_interrupts_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module external_pin_interrupts_test;
   logic                  clk = 1'h0;
   logic                  rstn = 1'h0;
   logic [2:0]            target = 3'h7;
   logic [2:0]            hold = 3'h0;
   logic [2:0]            pins;
   logic [2:0]            drv_en = 3'h0;
   logic [2:0]            drv_val = 3'h0;
   logic [2:0]            ack = 3'h0;
   logic                  sleep_a = 1'h0;
   logic                  idle = 1'h0;
   logic                  wdt_tick = 1'h0;
   logic [2:0]            tick_cnt = 3'h0;
   logic [3:0]            fuses = 4'h2;
   epi_pkg::epi_bus_req_t bus = '0;
   logic [31:0]           rdata;
   logic [2:0]            irq_req;
   logic                  irq_out;
   logic                  wake_req;
   logic                  rd_d = 1'h0;
   logic [31:0]           rnd = 32'h9CAC;
   logic [1:0]            sel;
   logic [2:0]            ef;
   logic [31:0]           exp_q[$];
   int                    err_total = 0;
   int                    n_checks = 0;

   epi_pin_src src (.clk(clk), .target(target), .hold(hold), .wake_req(wake_req), .pins(pins));

   epi_top dut (.clk(clk), .rstn(rstn), .ext_irq_pin_zero(pins[0]), .ext_irq_pin_one(pins[1]),
      .ext_irq_pin_two(pins[2]), .pin_drive_en(drv_en), .pin_drive_val(drv_val),
      .sleep_active(sleep_a), .sleep_is_idle(idle), .wdt_tick(wdt_tick),
      .startup_time_fuses(fuses), .irq_ack(ack), .bus_req(bus), .bus_rdata(rdata),
      .irq_req(irq_req), .irq_out(irq_out), .wake_req(wake_req), .osc_start());

   // Clock and watchdog tick every 8 cycles
   always #2 clk = ~clk;
   always @(posedge clk) begin
      tick_cnt <= tick_cnt + 3'h1;
      wdt_tick <= (tick_cnt == 3'h7);
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected status word from pending bits and effective levels
   function automatic logic [31:0] stat(input logic [2:0] pend);
      logic [2:0] lvl;
      lvl = (drv_en & drv_val) | (~drv_en & pins);
      return {21'h0, lvl, 5'h0, pend};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) rd_d <= bus.rd;
   always @(negedge clk) begin
      if (rd_d === 1'h1) begin
         chk(rdata, exp_q.pop_front());
      end
   end

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'h1;
      @(posedge clk);
      bus.wr <= 1'h0;
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'h1;
      exp_q.push_back(e);
      @(posedge clk);
      bus.rd <= 1'h0;
   endtask

   task automatic pin(input int ch, input logic v);
      @(posedge clk);
      target[ch] <= v;
      repeat (6) @(posedge clk);
      #1;
   endtask

   task automatic wait_wake;
      for (int i = 0; i < 80 && wake_req !== 1'h1; i++) @(posedge clk);
      #1;
   endtask

   // Level wake from deep sleep, k watchdog samples then release
   task automatic wake_try(input int k, input logic h, input logic ew, input logic ei);
      @(posedge clk);
      sleep_a <= 1'h1;
      target[0] <= 1'h0;
      hold[0] <= h;
      repeat (4) @(posedge clk);
      for (int i = 0; i < k; i++) begin
         @(posedge clk);
         for (int j = 0; j < 9 && wdt_tick !== 1'h1; j++) @(posedge clk);
      end
      target[0] <= 1'h1;
      wait_wake();
      chk(wake_req, ew);
      @(posedge clk);
      sleep_a <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      chk(irq_req[0], ei);
      @(posedge clk);
      hold[0] <= 1'h0;
      repeat (8) @(posedge clk);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      repeat (4) @(posedge clk);
      // Reset values, refused and random accesses
      bus_rd(epi_pkg::EPI_OFS_CTRL, 32'h0);
      bus_rd(epi_pkg::EPI_OFS_STATUS, stat(3'h0));
      bus_rd(epi_pkg::EPI_OFS_CLEAR, 32'h0);
      bus_wr(epi_pkg::EPI_OFS_STATUS, 32'hFFFFFFFF);
      rnd = lfsr(rnd);
      bus_wr({rnd[7:4] | 4'h1, rnd[3:0]}, rnd);
      bus_rd({rnd[7:4] | 4'h1, rnd[3:0]}, 32'h0);
      bus_wr(epi_pkg::EPI_OFS_ENABLE, {rnd[31:3], 3'h3});
      bus_rd(epi_pkg::EPI_OFS_ENABLE, 32'h3);
      bus_rd(epi_pkg::EPI_OFS_STATUS, stat(3'h0));
      // Every sense mode on inputs zero and one
      for (int ch = 0; ch < 2; ch++) begin
         for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            bus_wr(epi_pkg::EPI_OFS_CTRL, 32'(sel) << (2 * ch));
            bus_wr(epi_pkg::EPI_OFS_CLEAR, 32'h7);
            pin(ch, 1'h0);
            ef = (sel == epi_pkg::EPI_SENSE_ANY || sel == epi_pkg::EPI_SENSE_FALL) ? 3'(1 << ch) : 3'h0;
            chk(irq_req[ch], (sel == epi_pkg::EPI_SENSE_LOW) | (ef != 3'h0));
            bus_rd(epi_pkg::EPI_OFS_STATUS, stat(ef));
            bus_wr(epi_pkg::EPI_OFS_CLEAR, 32'h7);
            pin(ch, 1'h1);
            ef = (sel == epi_pkg::EPI_SENSE_ANY || sel == epi_pkg::EPI_SENSE_RISE) ? 3'(1 << ch) : 3'h0;
            bus_rd(epi_pkg::EPI_OFS_STATUS, stat(ef));
         end
      end
      // Input two polarity, mask and acknowledge
      bus_wr(epi_pkg::EPI_OFS_ENABLE, 32'h0);
      for (int p = 0; p < 2; p++) begin
         bus_wr(epi_pkg::EPI_OFS_CTRL, 32'(p) << 4);
         bus_wr(epi_pkg::EPI_OFS_CLEAR, 32'h7);
         pin(2, 1'h0);
         bus_rd(epi_pkg::EPI_OFS_STATUS, stat(p ? 3'h0 : 3'h4));
         pin(2, 1'h1);
         bus_rd(epi_pkg::EPI_OFS_STATUS, stat(3'h4));
      end
      chk(irq_req, 3'h0);
      bus_wr(epi_pkg::EPI_OFS_ENABLE, 32'h4);
      repeat (3) @(posedge clk);
      #1;
      chk({irq_out, irq_req}, 4'hC);
      @(posedge clk);
      ack <= 3'h4;
      @(posedge clk);
      ack <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
      chk({irq_out, irq_req}, 4'h0);
      // Pin driven by its own output driver
      bus_wr(epi_pkg::EPI_OFS_CTRL, 32'h2);
      bus_wr(epi_pkg::EPI_OFS_ENABLE, 32'h1);
      bus_wr(epi_pkg::EPI_OFS_CLEAR, 32'h7);
      @(posedge clk);
      drv_val <= 3'h1;
      drv_en <= 3'h1;
      @(posedge clk);
      drv_val <= 3'h0;
      repeat (4) @(posedge clk);
      #1;
      chk(irq_req, 3'h1);
      bus_rd(epi_pkg::EPI_OFS_STATUS, stat(3'h1));
      @(posedge clk);
      drv_en <= 3'h0;
      bus_wr(epi_pkg::EPI_OFS_CLEAR, 32'h7);
      // Clocked edges lost in deep sleep, caught in idle sleep
      @(posedge clk);
      sleep_a <= 1'h1;
      pin(0, 1'h0);
      bus_rd(epi_pkg::EPI_OFS_STATUS, stat(3'h0));
      chk(wake_req, 1'h0);
      pin(0, 1'h1);
      @(posedge clk);
      idle <= 1'h1;
      pin(0, 1'h0);
      chk({irq_out, wake_req}, 2'h3);
      @(posedge clk);
      sleep_a <= 1'h0;
      idle <= 1'h0;
      pin(0, 1'h1);
      // Level wake: too short, lost in start-up, held through
      bus_wr(epi_pkg::EPI_OFS_CTRL, 32'h0);
      bus_wr(epi_pkg::EPI_OFS_CLEAR, 32'h7);
      wake_try(1, 1'h0, 1'h0, 1'h0);
      wake_try(2, 1'h0, 1'h1, 1'h0);
      wake_try(2, 1'h1, 1'h1, 1'h1);
      // Clock-free edge on input two wakes from deep sleep
      bus_wr(epi_pkg::EPI_OFS_ENABLE, 32'h4);
      @(posedge clk);
      sleep_a <= 1'h1;
      pin(2, 1'h0);
      wait_wake();
      chk(wake_req, 1'h1);
      @(posedge clk);
      sleep_a <= 1'h0;
      pin(2, 1'h1);
      tally_and_finish();
   end

   // Hang guard
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
endmodule // external_pin_interrupts_test
`default_nettype wire
